// ---- decoder_pkg.sv ----
package decoder_pkg;

  // ----------------------------------------
  // widths and register port
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int TBL_PTR_W_DEF = 21;
  localparam int BANK_W_DEF = 4;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BANK = 8'h04;
  localparam logic [7:0] REG_TABLE_POINTER = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_LAST_WORD = 8'h10;
  localparam int CTRL_EXT_EN_BIT = 0;
  localparam logic CTRL_EXT_EN_RST = 1'b0;

  // ----------------------------------------
  // instruction cycle phases and cycle counts
  // ----------------------------------------
  localparam logic [1:0] PH_DECODE = 2'h0;
  localparam logic [1:0] PH_PRE = 2'h1;
  localparam logic [1:0] PH_ADDR = 2'h2;
  localparam logic [1:0] PH_END = 2'h3;
  localparam logic [1:0] CYCLES_ONE = 2'h1;
  localparam logic [1:0] CYCLES_TWO = 2'h2;
  localparam logic [1:0] CYCLES_THREE = 2'h3;

  // ----------------------------------------
  // opcode map
  // ----------------------------------------
  localparam logic [3:0] NIB_BIT_LO = 4'h8;
  localparam logic [3:0] NIB_BIT_SKIP = 4'hb;
  localparam logic [3:0] NIB_LIT = 4'hc;
  localparam logic [3:0] NIB_LIT_PTR = 4'hd;
  localparam logic [3:0] NIB_CTRL = 4'he;
  localparam logic [3:0] NIB_CONT = 4'hf;
  localparam logic [3:0] SUB_2W_BRANCH = 4'h3;
  localparam logic [3:0] SUB_CALLRET = 4'h4;
  localparam logic [3:0] SUB_TABLE = 4'h5;
  localparam logic [3:0] SUB_CBRANCH = 4'h6;
  localparam logic [3:0] SUB_EXT = 4'h9;
  localparam logic [3:0] SUB_BRANCH_LO = 4'ha;
  localparam logic [1:0] LIT_PTR_LOAD = 2'h0;
  localparam logic [1:0] LIT_NONE = 2'h3;
  localparam logic [1:0] TBL_NONE = 2'h0;
  localparam logic [1:0] TBL_POST_INC = 2'h1;
  localparam logic [1:0] TBL_POST_DEC = 2'h2;
  localparam logic [1:0] TBL_PRE_INC = 2'h3;

  typedef enum logic [1:0] {CLASS_BYTE, CLASS_BIT, CLASS_LITERAL, CLASS_CONTROL} op_class_e;
  typedef enum logic [1:0] {ST_EXEC, ST_SECOND, ST_FLUSH} state_e;

endpackage : decoder_pkg

// ---- instruction_format_decoder.sv ----
// Operation
// - Instructions are one 16-bit word, except four that span two consecutive words.
// - A single word splits into an opcode part and one or more operand fields.
// - Every instruction falls in the byte, bit, literal or control class.
// - Byte instructions carry file address, destination select and access select.
// - Destination zero sends the result to the working register, one to the file register.
// - Bit instructions carry file address, bit number and access select.
// - Literal instructions carry a literal, optionally a pointer select, or nothing.
// - Control instructions carry a program address, call/return mode, table mode, or nothing.
// - Second words have the top four bits set and run alone as a no-operation.
// - Single words take one cycle, two when a test is true or the counter changes.
// - Double-word instructions take two cycles, except a true two-word branch.
// - One instruction cycle is four clock periods.
// - A true two-word branch takes three cycles.
// - An extended group of eight instructions is recognised beside the standard set.
// - Access select clear uses the access region, set uses the bank select register.
// - Call/return mode set saves or restores shadows, clear leaves them alone.
// - Table mode picks no change, post-increment, post-decrement or pre-increment.
`timescale 1ns/1ps
`default_nettype none
module instruction_format_decoder #(
  parameter int TBL_PTR_W = decoder_pkg::TBL_PTR_W_DEF,
  parameter int BANK_W = decoder_pkg::BANK_W_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // program memory
  input wire logic [decoder_pkg::WORD_W-1:0] instr_word,
  output logic word_take,
  // execution feedback
  input wire logic cond_true,
  // register port
  input wire logic [decoder_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [decoder_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [decoder_pkg::DATA_W-1:0] reg_rdata,
  // decoded fields
  output var decoder_pkg::op_class_e op_class,
  output logic [5:0] opcode,
  output logic [7:0] file_addr,
  output logic [BANK_W+7:0] ram_addr,
  output logic use_bank_select,
  output logic result_to_working,
  output logic result_to_file,
  output logic [2:0] bit_num,
  output logic [7:0] literal,
  output logic ptr_load,
  output logic [1:0] ptr_sel,
  output logic [19:0] prog_addr,
  output logic two_word,
  output logic is_nop,
  output logic extended,
  output logic [2:0] ext_index,
  // timing
  output logic [1:0] phase,
  output logic cycle_start,
  output logic instr_done,
  output logic [1:0] instr_cycles,
  // shadow and table pointer
  output logic shadow_save,
  output logic shadow_restore,
  output logic [TBL_PTR_W-1:0] table_addr
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  if (TBL_PTR_W < 2 || TBL_PTR_W >= decoder_pkg::DATA_W) begin : g_bad_tbl
    $error("table pointer width out of range");
  end
  if (BANK_W < 1 || BANK_W > 8) begin : g_bad_bank
    $error("bank width out of range");
  end

  typedef struct packed {
    decoder_pkg::op_class_e op_class;
    logic [5:0] opcode;
    logic [7:0] file_addr;
    logic [BANK_W+7:0] ram_addr;
    logic mem_ref;
    logic use_bank;
    logic dest_file;
    logic [2:0] bit_num;
    logic [7:0] literal;
    logic ptr_load;
    logic [1:0] ptr_sel;
    logic [19:0] prog_addr;
    logic two_word;
    logic cond;
    logic cond2;
    logic pc_change;
    logic callret;
    logic is_return;
    logic shadow_mode;
    logic table_op;
    logic [1:0] table_mode;
    logic extended;
    logic [2:0] ext_index;
    logic is_nop;
    logic [decoder_pkg::WORD_W-1:0] last_word;
  } dec_s;

  dec_s dec_reg, dec_next;
  decoder_pkg::state_e state_reg, state_next;
  logic [1:0] phase_reg, phase_next;
  logic [1:0] cycles_reg, cycles_next;
  logic [1:0] last_cycles_reg, last_cycles_next;
  logic ext_en_reg, ext_en_next;
  logic [BANK_W-1:0] bank_reg, bank_next;
  logic [TBL_PTR_W-1:0] tbl_ptr_reg, tbl_ptr_next;
  logic [TBL_PTR_W-1:0] table_addr_reg, table_addr_next;
  logic [decoder_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic [3:0] nib;
  logic [3:0] sub;

  assign nib = instr_word[15:12];
  assign sub = instr_word[11:8];

  // ----------------------------------------
  // instruction cycle sequencer
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    phase_next = phase_reg + 2'h1;
    cycles_next = cycles_reg;
    last_cycles_next = last_cycles_reg;
    instr_done = 1'b0;
    if (phase_reg == decoder_pkg::PH_END)
    begin
      cycles_next = cycles_reg + 2'h1;
      case (state_reg)
        decoder_pkg::ST_EXEC:
        begin
          if (dec_reg.two_word)
            state_next = decoder_pkg::ST_SECOND;
          else if (dec_reg.pc_change || (dec_reg.cond && cond_true))
            state_next = decoder_pkg::ST_FLUSH;
          else
            instr_done = 1'b1;
        end
        decoder_pkg::ST_SECOND:
        begin
          if (dec_reg.cond2 && cond_true)
            state_next = decoder_pkg::ST_FLUSH;
          else
          begin
            state_next = decoder_pkg::ST_EXEC;
            instr_done = 1'b1;
          end
        end
        decoder_pkg::ST_FLUSH:
        begin
          state_next = decoder_pkg::ST_EXEC;
          instr_done = 1'b1;
        end
        default:
          state_next = decoder_pkg::ST_EXEC;
      endcase
      if (instr_done)
      begin
        last_cycles_next = cycles_reg + 2'h1;
        cycles_next = 2'h0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= decoder_pkg::ST_EXEC;
      phase_reg <= decoder_pkg::PH_DECODE;
      cycles_reg <= 2'h0;
      last_cycles_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cycles_reg <= cycles_next;
      last_cycles_reg <= last_cycles_next;
    end
  end

  assign cycle_start = (phase_reg == decoder_pkg::PH_DECODE);
  assign word_take = cycle_start && (state_reg != decoder_pkg::ST_FLUSH);

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  always_comb
  begin
    dec_next = dec_reg;
    if (cycle_start && state_reg == decoder_pkg::ST_EXEC)
    begin
      dec_next = '0;
      dec_next.last_word = instr_word;
      dec_next.opcode = instr_word[15:10];
      dec_next.file_addr = instr_word[7:0];
      dec_next.use_bank = instr_word[8];
      dec_next.ram_addr = instr_word[8] ? {bank_reg, instr_word[7:0]}
                                        : {{BANK_W{1'b0}}, instr_word[7:0]};
      if (nib == decoder_pkg::NIB_CONT)
      begin
        dec_next.op_class = decoder_pkg::CLASS_CONTROL;
        dec_next.is_nop = 1'b1;
      end
      else if (nib < decoder_pkg::NIB_BIT_LO)
      begin
        dec_next.op_class = decoder_pkg::CLASS_BYTE;
        dec_next.mem_ref = 1'b1;
        dec_next.dest_file = instr_word[9];
      end
      else if (nib < decoder_pkg::NIB_LIT)
      begin
        dec_next.op_class = decoder_pkg::CLASS_BIT;
        dec_next.mem_ref = 1'b1;
        dec_next.bit_num = instr_word[11:9];
        dec_next.cond = (nib == decoder_pkg::NIB_BIT_SKIP);
      end
      else if (nib < decoder_pkg::NIB_CTRL)
      begin
        dec_next.op_class = decoder_pkg::CLASS_LITERAL;
        dec_next.literal = instr_word[7:0];
        if (nib == decoder_pkg::NIB_LIT_PTR && instr_word[11:10] == decoder_pkg::LIT_PTR_LOAD)
        begin
          dec_next.ptr_load = 1'b1;
          dec_next.ptr_sel = instr_word[9:8];
        end
        else if (nib == decoder_pkg::NIB_LIT_PTR && instr_word[11:10] == decoder_pkg::LIT_NONE)
          dec_next.literal = 8'h00;
      end
      else
      begin
        dec_next.op_class = decoder_pkg::CLASS_CONTROL;
        if (sub <= decoder_pkg::SUB_2W_BRANCH)
        begin
          dec_next.two_word = 1'b1;
          dec_next.cond2 = (sub == decoder_pkg::SUB_2W_BRANCH);
          dec_next.prog_addr = {12'h000, instr_word[7:0]};
        end
        else if (sub == decoder_pkg::SUB_CALLRET)
        begin
          dec_next.callret = 1'b1;
          dec_next.pc_change = 1'b1;
          dec_next.is_return = instr_word[1];
          dec_next.shadow_mode = instr_word[0];
        end
        else if (sub == decoder_pkg::SUB_TABLE)
        begin
          dec_next.table_op = 1'b1;
          dec_next.table_mode = instr_word[1:0];
        end
        else if (sub == decoder_pkg::SUB_CBRANCH)
        begin
          dec_next.cond = 1'b1;
          dec_next.prog_addr = {12'h000, instr_word[7:0]};
        end
        else if (sub == decoder_pkg::SUB_EXT)
        begin
          dec_next.extended = ext_en_reg;
          dec_next.is_nop = !ext_en_reg;
          dec_next.ext_index = ext_en_reg ? instr_word[6:4] : 3'h0;
        end
        else if (sub >= decoder_pkg::SUB_BRANCH_LO)
        begin
          dec_next.pc_change = 1'b1;
          dec_next.prog_addr = {9'h000, instr_word[10:0]};
        end
      end
    end
    else if (cycle_start && state_reg == decoder_pkg::ST_SECOND)
    begin
      dec_next.prog_addr = {instr_word[11:0], dec_reg.prog_addr[7:0]};
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      dec_reg <= '0;
    else
      dec_reg <= dec_next;
  end

  assign op_class = dec_reg.op_class;
  assign opcode = dec_reg.opcode;
  assign file_addr = dec_reg.file_addr;
  assign ram_addr = dec_reg.ram_addr;
  assign use_bank_select = dec_reg.mem_ref && dec_reg.use_bank;
  assign result_to_working = (dec_reg.op_class == decoder_pkg::CLASS_BYTE) && !dec_reg.dest_file;
  assign result_to_file = (dec_reg.op_class == decoder_pkg::CLASS_BYTE) && dec_reg.dest_file;
  assign bit_num = dec_reg.bit_num;
  assign literal = dec_reg.literal;
  assign ptr_load = dec_reg.ptr_load;
  assign ptr_sel = dec_reg.ptr_sel;
  assign prog_addr = dec_reg.prog_addr;
  assign two_word = dec_reg.two_word;
  assign is_nop = dec_reg.is_nop;
  assign extended = dec_reg.extended;
  assign ext_index = dec_reg.ext_index;
  assign phase = phase_reg;
  assign instr_cycles = last_cycles_reg;

  assign shadow_save = (phase_reg == decoder_pkg::PH_END) && (state_reg == decoder_pkg::ST_EXEC)
                       && dec_reg.callret && dec_reg.shadow_mode && !dec_reg.is_return;
  assign shadow_restore = (phase_reg == decoder_pkg::PH_END) && (state_reg == decoder_pkg::ST_EXEC)
                          && dec_reg.callret && dec_reg.shadow_mode && dec_reg.is_return;

  // ----------------------------------------
  // table pointer and registers
  // ----------------------------------------
  always_comb
  begin
    tbl_ptr_next = tbl_ptr_reg;
    table_addr_next = table_addr_reg;
    ext_en_next = ext_en_reg;
    bank_next = bank_reg;
    rdata_next = '0;
    if (state_reg == decoder_pkg::ST_EXEC && dec_reg.table_op)
    begin
      if (phase_reg == decoder_pkg::PH_PRE && dec_reg.table_mode == decoder_pkg::TBL_PRE_INC)
        tbl_ptr_next = tbl_ptr_reg + 1'b1;
      if (phase_reg == decoder_pkg::PH_ADDR)
        table_addr_next = tbl_ptr_reg;
      if (phase_reg == decoder_pkg::PH_END && dec_reg.table_mode == decoder_pkg::TBL_POST_INC)
        tbl_ptr_next = tbl_ptr_reg + 1'b1;
      if (phase_reg == decoder_pkg::PH_END && dec_reg.table_mode == decoder_pkg::TBL_POST_DEC)
        tbl_ptr_next = tbl_ptr_reg - 1'b1;
    end
    if (reg_write)
    begin
      case (reg_addr)
        decoder_pkg::REG_CTRL: ext_en_next = reg_wdata[decoder_pkg::CTRL_EXT_EN_BIT];
        decoder_pkg::REG_BANK: bank_next = reg_wdata[BANK_W-1:0];
        decoder_pkg::REG_TABLE_POINTER: tbl_ptr_next = reg_wdata[TBL_PTR_W-1:0];
        default: ext_en_next = ext_en_reg;
      endcase
    end
    if (reg_read)
    begin
      case (reg_addr)
        decoder_pkg::REG_CTRL: rdata_next = {{(decoder_pkg::DATA_W-1){1'b0}}, ext_en_reg};
        decoder_pkg::REG_BANK: rdata_next = {{(decoder_pkg::DATA_W-BANK_W){1'b0}}, bank_reg};
        decoder_pkg::REG_TABLE_POINTER:
          rdata_next = {{(decoder_pkg::DATA_W-TBL_PTR_W){1'b0}}, tbl_ptr_reg};
        decoder_pkg::REG_STATUS:
          rdata_next = {{(decoder_pkg::DATA_W-8){1'b0}}, last_cycles_reg, state_reg,
                        phase_reg, dec_reg.op_class};
        decoder_pkg::REG_LAST_WORD:
          rdata_next = {{(decoder_pkg::DATA_W-decoder_pkg::WORD_W){1'b0}}, dec_reg.last_word};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tbl_ptr_reg <= '0;
      table_addr_reg <= '0;
      ext_en_reg <= decoder_pkg::CTRL_EXT_EN_RST;
      bank_reg <= '0;
      rdata_reg <= '0;
    end
    else
    begin
      tbl_ptr_reg <= tbl_ptr_next;
      table_addr_reg <= table_addr_next;
      ext_en_reg <= ext_en_next;
      bank_reg <= bank_next;
      rdata_reg <= rdata_next;
    end
  end

  assign table_addr = table_addr_reg;
  assign reg_rdata = rdata_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence four_on_done;
    ##4 instr_done;
  endsequence

  cycle_of_four_a: assert property (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
    else $error("instruction cycle is not four clocks");
  single_cycle_a: assert property ((instr_done && state_reg == decoder_pkg::ST_EXEC)
    |=> instr_cycles == decoder_pkg::CYCLES_ONE)
    else $error("single word took more than one cycle");
  flush_two_a: assert property ((phase_reg == decoder_pkg::PH_END
    && state_reg == decoder_pkg::ST_EXEC && !dec_reg.two_word && dec_reg.pc_change)
    |-> four_on_done ##1 (instr_cycles == decoder_pkg::CYCLES_TWO))
    else $error("counter change did not take two cycles");
  double_word_a: assert property ((phase_reg == decoder_pkg::PH_END
    && state_reg == decoder_pkg::ST_EXEC && dec_reg.two_word && !dec_reg.cond2)
    |-> four_on_done ##1 (instr_cycles == decoder_pkg::CYCLES_TWO))
    else $error("double word did not take two cycles");
  branch_three_a: assert property ((phase_reg == decoder_pkg::PH_END
    && state_reg == decoder_pkg::ST_SECOND && dec_reg.cond2 && cond_true)
    |-> four_on_done ##1 (instr_cycles == decoder_pkg::CYCLES_THREE))
    else $error("true two-word branch did not take three cycles");
  lone_second_a: assert property ((word_take && state_reg == decoder_pkg::ST_EXEC
    && instr_word[15:12] == decoder_pkg::NIB_CONT) |=> is_nop ##2 instr_done)
    else $error("lone second word did not run as a nop");
  dest_select_a: assert property ((op_class == decoder_pkg::CLASS_BYTE)
    |-> (result_to_working != result_to_file))
    else $error("byte result destination not unique");
  access_region_a: assert property ((dec_reg.mem_ref && !use_bank_select)
    |-> ram_addr[BANK_W+7:8] == '0)
    else $error("access region address uses a bank");
  shadow_fast_a: assert property ((shadow_save || shadow_restore)
    |-> dec_reg.shadow_mode && dec_reg.callret && !(shadow_save && shadow_restore))
    else $error("shadow update without fast mode");
  pre_inc_a: assert property ((state_reg == decoder_pkg::ST_EXEC && dec_reg.table_op
    && dec_reg.table_mode == decoder_pkg::TBL_PRE_INC && phase_reg == decoder_pkg::PH_PRE
    && !reg_write) |-> ##2 (table_addr == $past(tbl_ptr_reg, 2) + 1'b1))
    else $error("pre-increment address wrong");

endmodule : instruction_format_decoder
`default_nettype wire

// ---- prog_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module prog_mem (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // fetch port
  input wire logic word_take,
  output logic [15:0] instr_word
);
  // ----------------------------------------
  // program store
  // ----------------------------------------
  logic [15:0] mem [1024];
  logic [9:0] ptr_reg;
  logic [15:0] last_reg;

  initial
  begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ptr_reg <= 10'h000;
      last_reg <= 16'h0000;
    end
    else if (word_take)
    begin
      ptr_reg <= ptr_reg + 10'h001;
      last_reg <= mem[ptr_reg];
    end
  end

  // outside a fetch the bus shows the inverse of the last word
  assign instr_word = word_take ? mem[ptr_reg] : ~last_reg;
endmodule : prog_mem
`default_nettype wire

// ---- instruction_format_decoder_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module instruction_format_decoder_tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cond_true = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] instr_word;
  decoder_pkg::op_class_e op_class;
  logic [5:0] opcode;
  logic [7:0] file_addr, literal;
  logic [11:0] ram_addr;
  logic [2:0] bit_num, ext_index;
  logic [1:0] ptr_sel, instr_cycles, n_save, n_rest;
  logic [1:0] phase;
  logic cycle_start;
  logic [19:0] prog_addr;
  logic [20:0] table_addr, tp;
  logic word_take, use_bank_select, result_to_working, result_to_file, ptr_load;
  logic two_word, is_nop, extended, instr_done, shadow_save, shadow_restore;
  logic [3:0] bank = 4'h0;
  logic ext_en = 1'b0;
  logic [15:0] w;
  int mismatches = 0;
  int n_checks = 0;

  always #50 clock = ~clock;

  instruction_format_decoder u_dut (
    .clock, .rst, .instr_word, .word_take, .cond_true, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .op_class, .opcode, .file_addr, .ram_addr,
    .use_bank_select, .result_to_working, .result_to_file, .bit_num, .literal,
    .ptr_load, .ptr_sel, .prog_addr, .two_word, .is_nop, .extended, .ext_index,
    .phase, .cycle_start, .instr_done, .instr_cycles, .shadow_save,
    .shadow_restore, .table_addr
  );

  prog_mem u_mem (.clock, .rst, .word_take, .instr_word);

  always @(posedge clock)
  begin
    n_save += {1'b0, shadow_save};
    n_rest += {1'b0, shadow_restore};
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [1:0] exp_cycles(logic [15:0] x, logic c);
    logic [3:0] s;
    s = x[11:8];
    if (x[15:12] == 4'hb) return c ? 2'h2 : 2'h1;
    if (x[15:12] != 4'he) return 2'h1;
    if (s == 4'h3) return c ? 2'h3 : 2'h2;
    if (s < 4'h5 || s >= 4'ha) return 2'h2;
    if (s == 4'h6) return c ? 2'h2 : 2'h1;
    return 2'h1;
  endfunction : exp_cycles

  function automatic logic [1:0] exp_class(logic [3:0] n);
    return n < 4'h8 ? 2'h0 : n < 4'hc ? 2'h1 : n < 4'he ? 2'h2 : 2'h3;
  endfunction : exp_class

  task automatic wrap_up();
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  task automatic wait_done(output int n);
    for (n = 1; n <= 40; n++)
    begin
      @(posedge clock);
      #1;
      if (instr_done === 1'b1) return;
    end
    mismatches++;
    wrap_up();
  endtask : wait_done

  // one instruction fetched right after a completed one
  task automatic exec(input logic [15:0] w0, input logic [15:0] w1, input logic c);
    int n;
    logic [3:0] nb;
    logic [3:0] sb;
    logic [1:0] cy;
    nb = w0[15:12];
    sb = w0[11:8];
    cy = exp_cycles(w0, c);
    wait_done(n);
    u_mem.mem[u_mem.ptr_reg] = w0;
    u_mem.mem[u_mem.ptr_reg + 10'h001] = w1;
    n_save = 2'h0;
    n_rest = 2'h0;
    @(posedge clock);
    cond_true <= c;
    wait_done(n);
    chk({phase, cycle_start}, 3'h6);
    chk(opcode, w0[15:10]);
    chk(two_word, nb == 4'he && sb < 4'h4);
    if (nb != 4'hf) chk(op_class, exp_class(nb));
    if (nb < 4'hc) chk(file_addr, w0[7:0]);
    if (nb < 4'hc) chk(ram_addr, w0[8] ? {bank, w0[7:0]} : {4'h0, w0[7:0]});
    if (nb < 4'hc) chk(use_bank_select, w0[8]);
    if (nb < 4'h8) chk({result_to_file, result_to_working}, {w0[9], !w0[9]});
    else if (nb < 4'hc) chk(bit_num, w0[11:9]);
    else if (nb == 4'hd && w0[11:10] == 2'h0) chk({ptr_load, ptr_sel}, {1'b1, w0[9:8]});
    else if (nb < 4'he) chk(literal, nb == 4'hd && w0[11:10] == 2'h3 ? 8'h00 : w0[7:0]);
    else if (nb == 4'hf) chk(is_nop, 1'b1);
    else if (sb < 4'h4) chk(prog_addr, {w1[11:0], w0[7:0]});
    else if (sb == 4'h4) chk({n_save, n_rest}, {1'b0, w0[0] & !w0[1], 1'b0, &w0[1:0]});
    else if (sb >= 4'ha) chk(prog_addr[10:0], w0[10:0]);
    else if (sb == 4'h9 && ext_en) chk({extended, ext_index}, {1'b1, w0[6:4]});
    else if (sb == 4'h9) chk({extended, is_nop}, 2'h1);
    else if (sb == 4'h5)
    begin
      chk(table_addr, w0[1:0] == 2'h3 ? tp + 21'h1 : tp);
      tp = w0[0] ? tp + 21'h1 : w0[1] ? tp - 21'h1 : tp;
    end
    chk(n + 1, 4 * cy);
    // read before the next word replaces the decode
    rd(decoder_pkg::REG_LAST_WORD, {16'h0, w0});
    if (nb == 4'he && sb == 4'h5) rd(decoder_pkg::REG_TABLE_POINTER, {11'h0, tp});
    chk(instr_cycles, cy);
  endtask : exec

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h89ba6e76));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    // first decode after reset: phase 1, state exec, byte class
    rd(decoder_pkg::REG_STATUS, 32'h4);
    rd(decoder_pkg::REG_CTRL, 32'h0);
    rd(decoder_pkg::REG_TABLE_POINTER, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'hffffffff);
    wr(decoder_pkg::REG_LAST_WORD, 32'h1234);
    rd(decoder_pkg::REG_LAST_WORD, 32'h0);
    wr(decoder_pkg::REG_BANK, 32'hfffffff5);
    bank = 4'h5;
    rd(decoder_pkg::REG_BANK, 32'h5);
    for (int k = 0; k < 40; k++)
    begin
      w = 16'($urandom);
      w[15:12] = 4'($urandom % 14);
      exec(w, 16'h0, 1'($urandom));
    end
    for (int k = 0; k < 8; k++)
      exec({4'he, 4'(k / 2), 8'($urandom)}, {4'hf, 12'($urandom)}, k[0]);
    exec(16'hf5a3, 16'h0, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      exec({4'hb, 12'($urandom)}, 16'h0, k[0]);
      exec({8'he6, 8'($urandom)}, 16'h0, k[0]);
    end
    for (int k = 0; k < 4; k++)
      exec({8'he4, 6'h0, 2'(k)}, 16'h0, 1'b1);
    for (int k = 0; k < 6; k++)
      exec({4'he, 4'(k + 10), 8'($urandom)}, 16'h0, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      tp = 21'($urandom % 1000 + 10);
      wr(decoder_pkg::REG_TABLE_POINTER, {11'h0, tp});
      exec({8'he5, 6'h0, 2'(k)}, 16'h0, 1'b0);
    end
    exec(16'he930, 16'h0, 1'b0);
    wr(decoder_pkg::REG_CTRL, 32'h1);
    ext_en = 1'b1;
    rd(decoder_pkg::REG_CTRL, 32'h1);
    for (int k = 0; k < 8; k++)
      exec({8'he9, 1'b0, 3'(k), 4'h0}, 16'h0, 1'b0);
    wrap_up();
  end
endmodule : instruction_format_decoder_tb_top
`default_nettype wire
